// file: hw/avsdm_cfg.svh
// Register map, field layout, reset values and timing of the A/V delay meter
// -----------------------------------------------------------------
// -----------------------------------------------------------------
`ifndef AVSDM_CFG_SVH
`define AVSDM_CFG_SVH

// Register byte offsets
`define AVSDM_CTRL_OFS    8'h00
`define AVSDM_OFFSET_OFS  8'h04
`define AVSDM_STATUS_OFS  8'h08
`define AVSDM_RESULT_OFS  8'h0C
`define AVSDM_MINMAX_OFS  8'h10

// Control register fields and reset values
`define AVSDM_CTRL_EXT    0
`define AVSDM_CTRL_GRP    1
`define AVSDM_CTRL_PAIR   3
`define AVSDM_CTRL_CHB    4
`define AVSDM_CTRL_PLACE  5
`define AVSDM_CTRL_F625   7
`define AVSDM_CTRL_OFFEN  8
`define AVSDM_CTRL_FRAMES 9
`define AVSDM_CTRL_W      10
`define AVSDM_CTRL_RST    10'h000
`define AVSDM_OFFSET_RST  16'h0000

// Status register fields
`define AVSDM_STAT_TRIG   0
`define AVSDM_STAT_RES    2
`define AVSDM_STAT_TMO    3

// Trigger thresholds (audio one is decimal 1000)
`define AVSDM_LUMA_TH     32'h0000_0100
`define AVSDM_AUD_TH      32'h0000_03E8

// Tested lines
`define AVSDM_VI_LINE     11'h00D
`define AVSDM_AV_LINE_525 11'h02D
`define AVSDM_AV_LINE_625 11'h026

// Timing: clock period, one millisecond, timeout span
`define AVSDM_CLK_NS      4
`define AVSDM_MS_NS       1000000
`define AVSDM_TMO_MS      2000
`define AVSDM_MS_CYC      (`AVSDM_MS_NS / `AVSDM_CLK_NS)
`define AVSDM_TMO_CYC     (`AVSDM_TMO_MS * `AVSDM_MS_CYC)

`endif

// file: hw/avsdm_pkg.sv
// Types shared by the A/V delay meter modules
package avsdm_pkg;

    // Line placement of the test signal
    typedef enum logic [1:0] {
        PLACE_GEN = 2'b00,
        PLACE_VI  = 2'b01,
        PLACE_AV  = 2'b10
    } avsdm_place_t;

    // Trigger pairing state
    typedef enum logic [1:0] {
        TRIG_WAIT_BOTH = 2'b00,
        TRIG_HAVE_VID  = 2'b01,
        TRIG_HAVE_AUD  = 2'b10
    } avsdm_trig_t;

endpackage : avsdm_pkg

// file: hw/avsdm_tick_div.sv
// Divider giving a one-cycle enable pulse every DIV clocks
`timescale 1ns/1ns
`default_nettype none

module avsdm_tick_div #(
    parameter int DIV = 250000
) (
    // Clock and reset
    input  wire logic clk,
    input  wire logic rstn,
    // Enable pulse
    output logic      tick
);

    localparam int CW = (DIV > 1) ? $clog2(DIV) : 1;

    logic [CW-1:0] cnt_q;
    wire logic     wrap = (cnt_q == CW'(DIV - 1));

    // Count up one period, pulse in the cycle after the last count
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            cnt_q <= '0;
            tick  <= 1'b0;
        end
        else
        begin
            cnt_q <= wrap ? '0 : cnt_q + CW'(1);
            tick  <= wrap;
        end
    end

endmodule : avsdm_tick_div

`default_nettype wire

// file: hw/avsdm_cross_det.sv
// Rising threshold crossing detector for one sample stream
`timescale 1ns/1ns
`default_nettype none

module avsdm_cross_det #(
    parameter int W      = 10,
    parameter int TH     = 32'h0000_0100,
    parameter bit SIGNED = 1'b0
) (
    // Clock and reset
    input  wire logic         clk,
    input  wire logic         rstn,
    // Sample stream
    input  wire logic         sampValid,
    input  wire logic [W-1:0] sample,
    input  wire logic         gate,
    input  wire logic         clearPrev,
    // Crossing pulse
    output logic              hit
);

    localparam logic signed [W:0] THR = (W+1)'(TH);

    logic signed [W:0] prev_q;
    logic              prevOk_q;
    wire logic signed [W:0] cur = {SIGNED & sample[W-1], sample};

    // Strictly below, then strictly above; a fall never fires
    assign hit = sampValid && gate && prevOk_q
                 && (prev_q < THR) && (cur > THR);

    // Previous gated sample; cleared so no stale pair spans a gap
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            prev_q   <= '0;
            prevOk_q <= 1'b0;
        end
        else if (clearPrev)
        begin
            prevOk_q <= 1'b0;
        end
        else if (sampValid && gate)
        begin
            prev_q   <= cur;
            prevOk_q <= 1'b1;
        end
    end

endmodule : avsdm_cross_det

`default_nettype wire

// file: hw/avsdm_delay_meter.sv
// A/V delay meter: trigger detection, interval timing and APB registers
//
// Local design decisions: the address map and the APB slave port.
`timescale 1ns/1ns
`default_nettype none
`include "avsdm_cfg.svh"

module avsdm_delay_meter #(
    parameter int MS_CYC  = `AVSDM_MS_CYC,
    parameter int TMO_CYC = `AVSDM_TMO_CYC
) (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rstn,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Video samples of both serial channels
    input  wire logic        vidValid,
    input  wire logic [9:0]  vidLumaA,
    input  wire logic [9:0]  vidLumaB,
    input  wire logic [10:0] lineNum,
    input  wire logic        hBlank,
    input  wire logic        vBlank,
    input  wire logic        frameStart,
    // Embedded audio
    input  wire logic        embValid,
    input  wire logic [1:0]  embGroup,
    input  wire logic        embPair,
    input  wire logic [23:0] embSample,
    // External digital audio
    input  wire logic        extValid,
    input  wire logic [23:0] extSample,
    // Results
    output logic      [1:0]  trigState,
    output logic             resultStrobe,
    output logic      [31:0] resultValue,
    output logic             timeoutFlag
);

    // -------------------------------------------------------------
    // Register bus
    // -------------------------------------------------------------
    logic [`AVSDM_CTRL_W-1:0] ctrl_q;
    logic [15:0]              off_q;
    logic [31:0]              prdata_q;
    logic                     pready_q;
    logic                     pslverr_q;
    logic                     tmo_q;
    logic                     haveRes_q;
    logic [31:0]              result_q;
    logic                     strobe_q;
    logic [15:0]              min_q;
    logic [15:0]              max_q;
    logic                     mmValid_q;
    avsdm_pkg::avsdm_trig_t   state_q;
    avsdm_pkg::avsdm_trig_t   state_d;

    // Address decode
    wire logic hitCtrl = (paddr == `AVSDM_CTRL_OFS);
    wire logic hitOff  = (paddr == `AVSDM_OFFSET_OFS);
    wire logic hitStat = (paddr == `AVSDM_STATUS_OFS);
    wire logic hitRes  = (paddr == `AVSDM_RESULT_OFS);
    wire logic hitMm   = (paddr == `AVSDM_MINMAX_OFS);
    wire logic hitAny  = hitCtrl | hitOff | hitStat | hitRes | hitMm;
    wire logic setup   = psel && !penable;
    wire logic wrEn    = psel && penable && pready_q && pwrite;
    wire logic wrCtrl  = wrEn && hitCtrl;
    wire logic wrStat  = wrEn && hitStat;

    // Read data; captured in setup so it sits in a flop for access
    wire logic [31:0] rdMux =
        hitCtrl ? {22'h0, ctrl_q} :
        hitOff  ? {16'h0, off_q} :
        hitStat ? {28'h0, tmo_q, haveRes_q, state_q} :
        hitRes  ? result_q :
        hitMm   ? {max_q, min_q} : 32'h0;

    // One wait-free access phase; unmapped offsets answer with an error
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= 32'h0;
        end
        else
        begin
            pready_q  <= setup;
            pslverr_q <= setup && !hitAny;
            prdata_q  <= (setup && !pwrite) ? rdMux : 32'h0;
        end
    end

    // Control and offset registers
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            ctrl_q <= `AVSDM_CTRL_RST;
            off_q  <= `AVSDM_OFFSET_RST;
        end
        else
        begin
            if (wrCtrl)
                ctrl_q <= pwdata[`AVSDM_CTRL_W-1:0];
            if (wrEn && hitOff)
                off_q <= pwdata[15:0];
        end
    end

    // Control fields
    wire logic       srcExt  = ctrl_q[`AVSDM_CTRL_EXT];
    wire logic [1:0] grpSel  = ctrl_q[`AVSDM_CTRL_GRP +: 2];
    wire logic       pairSel = ctrl_q[`AVSDM_CTRL_PAIR];
    wire logic       chanB   = ctrl_q[`AVSDM_CTRL_CHB];
    wire logic [1:0] place   = ctrl_q[`AVSDM_CTRL_PLACE +: 2];
    wire logic       fmt625  = ctrl_q[`AVSDM_CTRL_F625];
    wire logic       offEn   = ctrl_q[`AVSDM_CTRL_OFFEN];
    wire logic       unitFrm = ctrl_q[`AVSDM_CTRL_FRAMES];

    // A write that moves group or pair invalidates held extremes
    wire logic selChg = wrCtrl
        && ((pwdata[`AVSDM_CTRL_GRP +: 2] != grpSel)
        || (pwdata[`AVSDM_CTRL_PAIR] != pairSel));
    wire logic srcChg = wrCtrl && (pwdata[`AVSDM_CTRL_EXT] != srcExt);

    // -------------------------------------------------------------
    // Trigger detection
    // -------------------------------------------------------------
    logic vidHit;
    logic audHit;
    logic msTick;

    // Line gate per placement; the reserved code tests nothing
    wire logic [9:0]  luma   = chanB ? vidLumaB : vidLumaA;
    wire logic [10:0] avLine = fmt625 ? `AVSDM_AV_LINE_625
                                      : `AVSDM_AV_LINE_525;
    wire logic lineGate =
        (place == avsdm_pkg::PLACE_GEN) ? 1'b1 :
        (place == avsdm_pkg::PLACE_VI) ? (lineNum == `AVSDM_VI_LINE) :
        (place == avsdm_pkg::PLACE_AV) ? (lineNum == avLine) : 1'b0;
    wire logic blank = hBlank || vBlank;

    // Audio source and channel pair
    wire logic embMatch = embValid && (embGroup == grpSel)
                          && (embPair == pairSel);
    wire logic        audValid  = srcExt ? extValid : embMatch;
    wire logic [23:0] audSample = srcExt ? extSample : embSample;

    // Blanking restarts the luma history so edges into or out of it are dropped
    avsdm_cross_det #(
        .W      (10),
        .TH     (`AVSDM_LUMA_TH),
        .SIGNED (1'b0)
    ) u_vidDet (
        .clk       (clk),
        .rstn      (rstn),
        .sampValid (vidValid),
        .sample    (luma),
        .gate      (lineGate && !blank),
        .clearPrev (blank),
        .hit       (vidHit)
    );

    // A new audio selection must not pair with the old stream's sample
    avsdm_cross_det #(
        .W      (24),
        .TH     (`AVSDM_AUD_TH),
        .SIGNED (1'b1)
    ) u_audDet (
        .clk       (clk),
        .rstn      (rstn),
        .sampValid (audValid),
        .sample    (audSample),
        .gate      (lineGate),
        .clearPrev (selChg || srcChg),
        .hit       (audHit)
    );

    // -------------------------------------------------------------
    // Interval timing
    // -------------------------------------------------------------
    avsdm_tick_div #(
        .DIV (MS_CYC)
    ) u_msDiv (
        .clk  (clk),
        .rstn (rstn),
        .tick (msTick)
    );

    logic [29:0] cyc_q;
    logic [15:0] ms_q;
    logic [15:0] frm_q;
    logic [29:0] stCyc_q;
    logic [15:0] stMs_q;
    logic [15:0] stFrm_q;
    logic        pub;
    logic        stamp;
    logic        tmoEv;

    // Free-running time bases; 30 bits span over four seconds
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            cyc_q <= 30'h0;
            ms_q  <= 16'h0;
            frm_q <= 16'h0;
        end
        else
        begin
            cyc_q <= cyc_q + 30'h1;
            if (msTick)
                ms_q <= ms_q + 16'h1;
            if (frameStart)
                frm_q <= frm_q + 16'h1;
        end
    end

    // Elapsed time since the first trigger; modular differences
    wire logic [29:0] waitCyc = cyc_q - stCyc_q;
    wire logic        vidFirst = (state_q == avsdm_pkg::TRIG_HAVE_VID);
    wire logic        audFirst = (state_q == avsdm_pkg::TRIG_HAVE_AUD);
    wire logic        tmoHit = (vidFirst || audFirst)
                               && (waitCyc >= 30'(TMO_CYC));
    wire logic [15:0] elapMs  = ms_q - stMs_q;
    wire logic [15:0] elapFrm = frm_q - stFrm_q;

    // Positive delay means audio arrives after video
    wire logic [15:0] dMs  = vidFirst ? elapMs :
                             audFirst ? 16'h0 - elapMs : 16'h0;
    wire logic [15:0] dFrm = vidFirst ? elapFrm :
                             audFirst ? 16'h0 - elapFrm : 16'h0;
    wire logic [15:0] offUse = offEn ? off_q : 16'h0;
    wire logic [16:0] adjMs  = {dMs[15], dMs}
                               - {offUse[15], offUse};

    // Pairing of triggers; a repeat of the held kind is ignored
    always_comb
    begin
        state_d = state_q;
        pub     = 1'b0;
        stamp   = 1'b0;
        tmoEv   = 1'b0;
        case (state_q)
            avsdm_pkg::TRIG_WAIT_BOTH:
            begin
                if (vidHit && audHit)
                    pub = 1'b1;
                else if (vidHit)
                begin
                    state_d = avsdm_pkg::TRIG_HAVE_VID;
                    stamp   = 1'b1;
                end
                else if (audHit)
                begin
                    state_d = avsdm_pkg::TRIG_HAVE_AUD;
                    stamp   = 1'b1;
                end
            end
            avsdm_pkg::TRIG_HAVE_VID:
            begin
                if (audHit)
                begin
                    pub     = 1'b1;
                    state_d = avsdm_pkg::TRIG_WAIT_BOTH;
                end
                else if (tmoHit)
                begin
                    tmoEv   = 1'b1;
                    state_d = avsdm_pkg::TRIG_WAIT_BOTH;
                end
            end
            avsdm_pkg::TRIG_HAVE_AUD:
            begin
                if (vidHit)
                begin
                    pub     = 1'b1;
                    state_d = avsdm_pkg::TRIG_WAIT_BOTH;
                end
                else if (tmoHit)
                begin
                    tmoEv   = 1'b1;
                    state_d = avsdm_pkg::TRIG_WAIT_BOTH;
                end
            end
            default:
                state_d = avsdm_pkg::TRIG_WAIT_BOTH;
        endcase
    end

    // State, stamps and published result
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            state_q   <= avsdm_pkg::TRIG_WAIT_BOTH;
            stCyc_q   <= 30'h0;
            stMs_q    <= 16'h0;
            stFrm_q   <= 16'h0;
            strobe_q  <= 1'b0;
            result_q  <= 32'h0;
            haveRes_q <= 1'b0;
            tmo_q     <= 1'b0;
        end
        else
        begin
            state_q  <= state_d;
            strobe_q <= pub;
            if (stamp)
            begin
                stCyc_q <= cyc_q;
                stMs_q  <= ms_q;
                stFrm_q <= frm_q;
            end
            if (pub)
            begin
                result_q  <= unitFrm ? {{16{dFrm[15]}}, dFrm}
                                     : {{15{adjMs[16]}}, adjMs};
                haveRes_q <= 1'b1;
            end
            // Timeout is sticky; a new event beats a write-one clear
            tmo_q <= tmoEv || (tmo_q && !(wrStat && pwdata[`AVSDM_STAT_TMO]));
        end
    end

    // -------------------------------------------------------------
    // Held minimum and maximum (ms, low 16 bits)
    // -------------------------------------------------------------
    wire logic        mmClr = selChg || (wrEn && hitMm);
    wire logic [15:0] newMs = adjMs[15:0];
    wire logic        fresh = mmClr || !mmValid_q;
    wire logic        newLo = fresh || ($signed(newMs) < $signed(min_q));
    wire logic        newHi = fresh || ($signed(newMs) > $signed(max_q));

    // A result landing with a clear restarts the extremes from it
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            mmValid_q <= 1'b0;
            min_q     <= 16'h0;
            max_q     <= 16'h0;
        end
        else if (pub)
        begin
            mmValid_q <= 1'b1;
            if (newLo)
                min_q <= newMs;
            if (newHi)
                max_q <= newMs;
        end
        else if (mmClr)
        begin
            mmValid_q <= 1'b0;
            min_q     <= 16'h0;
            max_q     <= 16'h0;
        end
    end

    // Outputs, all from flops
    assign prdata       = prdata_q;
    assign pready       = pready_q;
    assign pslverr      = pslverr_q;
    assign trigState    = state_q;
    assign resultStrobe = strobe_q;
    assign resultValue  = result_q;
    assign timeoutFlag  = tmo_q;

    // -------------------------------------------------------------
    // Checks
    // -------------------------------------------------------------
    default clocking avsdmCb @(posedge clk);
    endclocking
    default disable iff (!rstn);

    AST_VID_UP: assert property (vidHit |-> luma > 10'(`AVSDM_LUMA_TH))
        else $error("video trigger without luma above threshold");
    AST_AUD_UP: assert property (audHit |-> int'($signed(audSample)) > int'(`AVSDM_AUD_TH))
        else $error("audio trigger without sample above threshold");
    AST_VI_LINE: assert property (vidHit && place == avsdm_pkg::PLACE_VI
        |-> lineNum == `AVSDM_VI_LINE)
        else $error("vertical-interval trigger off the tested line");
    AST_AV_LINE: assert property (vidHit && place == avsdm_pkg::PLACE_AV
        |-> lineNum == (fmt625 ? `AVSDM_AV_LINE_625 : `AVSDM_AV_LINE_525))
        else $error("active-video trigger off the tested line");
    AST_GEN_BLANK: assert property (vidHit |-> !hBlank && !vBlank)
        else $error("video trigger inside blanking");
    AST_PUBLISH: assert property (resultStrobe |->
        $past(vidHit && audHit)
        || ($past(audHit) && $past(state_q) == avsdm_pkg::TRIG_HAVE_VID)
        || ($past(vidHit) && $past(state_q) == avsdm_pkg::TRIG_HAVE_AUD))
        else $error("result published without a trigger pair");
    AST_STATUS: assert property (vidHit && !audHit
        && state_q == avsdm_pkg::TRIG_WAIT_BOTH
        |=> trigState == avsdm_pkg::TRIG_HAVE_VID ##1 1'b1)
        else $error("status does not show held video trigger");
    AST_OFFSET: assert property (pub && offEn && !unitFrm && dMs == off_q
        |=> resultStrobe && resultValue == 32'h0)
        else $error("delay equal to offset does not read zero");
    AST_UNIT: assert property (pub && unitFrm
        |=> resultValue[15:0] == $past(dFrm))
        else $error("frame result differs from frame count");
    AST_TMO: assert property (tmoHit && !audHit && !vidHit
        |=> state_q == avsdm_pkg::TRIG_WAIT_BOTH && timeoutFlag)
        else $error("timeout did not return to waiting");
    AST_MM_CLR: assert property (selChg && !pub
        |=> !mmValid_q && min_q == 16'h0 && max_q == 16'h0)
        else $error("extremes kept after selection change");

endmodule : avsdm_delay_meter

`default_nettype wire

// file: dv/avsdm_src_model.sv
// Test-signal source model driving the delay meter's video and audio inputs
`timescale 1ns/1ns
`default_nettype none

module avsdm_src_model #(
    parameter int GAP = 5000,
    parameter int FRM = 100
) (
    // Clock
    input  wire logic   clk,
    // Video
    output logic        vidValid,
    output logic [9:0]  vidLumaA,
    output logic [9:0]  vidLumaB,
    output logic [10:0] lineNum,
    output logic        hBlank,
    output logic        vBlank,
    output logic        frameStart,
    // Audio
    output logic        embValid,
    output logic [1:0]  embGroup,
    output logic        embPair,
    output logic [23:0] embSample,
    output logic        extValid,
    output logic [23:0] extSample
);
    // ----------------------------------------
    // Generator tasks
    // ----------------------------------------
    // Idle in blanking so no stray sample can count
    initial
    begin
        {vidValid, vBlank, embValid, extValid, embPair, embGroup, lineNum} = '0;
        {vidLumaA, vidLumaB, embSample, extSample} = '0;
        hBlank = 1'b1;
    end

    // Frame pulse every FRM clocks, free running as on a real feed
    int frmCnt = 0;
    always @(posedge clk)
    begin
        frmCnt     <= (frmCnt == FRM - 1) ? 0 : frmCnt + 1;
        frameStart <= (frmCnt == FRM - 1);
    end

    // One rising luma crossing on the given channel
    task automatic vid(input logic [10:0] ln, input logic chB);
        for (int i = 0; i < 2; i++)
        begin
            @(posedge clk);
            {lineNum, hBlank, vidValid} <= {ln, 2'b01};
            vidLumaA <= chB ? 10'h000 : (i ? 10'h1FF : 10'h0F0);
            vidLumaB <= chB ? (i ? 10'h1FF : 10'h0F0) : 10'h000;
        end
        @(posedge clk);
        {hBlank, vidValid} <= 2'b10;
        vidLumaA <= ~vidLumaA; // Stale value would hide a sampling slip
    endtask : vid

    // Luma rise straight out of vertical blanking; must never count
    task automatic vrise(input logic [10:0] ln);
        @(posedge clk);
        {lineNum, vBlank, hBlank, vidValid, vidLumaA} <= {ln, 3'b101, 10'h0F0};
        @(posedge clk);
        {vBlank, vidLumaA} <= {1'b0, 10'h1FF};
        @(posedge clk);
        {hBlank, vidValid} <= 2'b10;
    endtask : vrise

    // One rising audio crossing, random level above threshold
    task automatic aud(input logic [10:0] ln, input logic ext, input logic [1:0] g,
                       input logic p);
        logic [23:0] v;
        v = 24'(1001 + $urandom % 4000);
        for (int i = 0; i < 2; i++)
        begin
            @(posedge clk);
            {lineNum, extValid, embValid, embGroup, embPair} <= {ln, ext, !ext, g, p};
            extSample <= i ? v : 24'h000000;
            embSample <= i ? v : 24'h000000;
        end
        @(posedge clk);
        {extValid, embValid} <= 2'b00;
    endtask : aud

    // Spacing inside a pair stays under the timeout span
    task automatic pause(input int n);
        repeat (n) @(posedge clk);
    endtask : pause

    // Quiet span between pairs, scaled like the other counts
    task automatic gap;
        pause(GAP);
    endtask : gap
endmodule : avsdm_src_model
`default_nettype wire

// file: dv/tb_avsdm_delay_meter.sv
// Self-checking bench for the A/V delay meter
`timescale 1ns/1ns
`default_nettype none

module tb_avsdm_delay_meter;
    // ----------------------------------------
    // Signals, instances and checking
    // ----------------------------------------
    localparam int MS = 10;
    logic        clk, rstn, psel, penable, pwrite, pready, pslverr, resultStrobe;
    logic        timeoutFlag, vidValid, hBlank, vBlank, frameStart, embValid, embPair, extValid;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, resultValue, e;
    logic [1:0]  trigState, embGroup;
    logic [9:0]  vidLumaA, vidLumaB;
    logic [10:0] lineNum;
    logic [23:0] embSample, extSample;
    logic [32:0] rdQ [$];
    logic [31:0] resQ [$];
    int          mismatches, compares;

    avsdm_delay_meter #(.MS_CYC(MS), .TMO_CYC(2000)) avsdm_delay_meter_i (.clk, .rstn,
        .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .vidValid,
        .vidLumaA, .vidLumaB, .lineNum, .hBlank, .vBlank, .frameStart,
        .embValid, .embGroup, .embPair, .embSample, .extValid, .extSample, .trigState,
        .resultStrobe, .resultValue, .timeoutFlag);
    avsdm_src_model #(.GAP(5000)) avsdm_src_model_i (.clk, .vidValid, .vidLumaA,
        .vidLumaB, .lineNum, .hBlank, .vBlank, .frameStart, .embValid, .embGroup,
        .embPair, .embSample,
        .extValid, .extSample);

    initial
    begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    task automatic miss(input logic [32:0] got, input logic [32:0] exp);
        mismatches++;
        $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    endtask : miss

    // APB master: hold the request until pready is sampled high
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, wr, a, d};
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        {psel, penable} <= 2'b00;
    endtask : apb

    task automatic rd(input logic [7:0] a, input logic [32:0] exp);
        rdQ.push_back(exp);
        apb(1'b0, a, 32'h0);
    endtask : rd

    // Outputs are judged against the oldest note; results within one count, ms tick or frame
    always @(posedge clk)
    begin
        if (resultStrobe === 1'b1)
        begin
            e = resQ.size() ? resQ.pop_front() : 32'hX; // An unexpected result never matches
            compares++;
            if (resultValue !== e && resultValue !== e + 1 && resultValue !== e - 1)
                miss({1'b0, resultValue}, {1'b0, e});
        end
        if (psel && penable && pready === 1'b1 && !pwrite)
        begin
            compares++;
            if ({pslverr, prdata} !== rdQ[0])
                miss({pslverr, prdata}, rdQ[0]);
            void'(rdQ.pop_front());
        end
    end

    task automatic end_of_test;
        $display("compares=%0d mismatches=%0d", compares, mismatches);
        if (mismatches == 0 && compares > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : end_of_test

    // Whole run is near 23200 cycles
    initial
    begin
        repeat (40000) @(posedge clk);
        miss(33'h0, 33'h1);
        end_of_test();
    end

    initial
    begin
        {rstn, psel, penable, pwrite, paddr, pwdata, mismatches, compares} = '0;
        void'($urandom(17));
        repeat (10) @(posedge clk);
        rstn <= 1'b1;
        rd(8'h00, 33'h0);
        apb(1'b1, 8'h00, 32'h11);
        rd(8'h00, 33'h011);
        rd(8'h14, 33'h1_0000_0000);
        $display("register test done");
        // Channel B video leads external audio by 300 cycles
        avsdm_src_model_i.vid(11'h005, 1'b1);
        rd(8'h08, 33'h001);
        resQ.push_back(32'd30);
        avsdm_src_model_i.pause(294);
        avsdm_src_model_i.aud(11'h005, 1'b1, 2'd0, 1'b0);
        $display("video-first test done");
        // Embedded group 2 pair 1 leads by 200 cycles, offset equal to that delay
        avsdm_src_model_i.gap();
        apb(1'b1, 8'h04, 32'hFFEC);
        apb(1'b1, 8'h00, 32'h10C);
        avsdm_src_model_i.aud(11'h006, 1'b0, 2'd0, 1'b1);
        avsdm_src_model_i.aud(11'h006, 1'b0, 2'd2, 1'b0);
        avsdm_src_model_i.pause(100);
        avsdm_src_model_i.aud(11'h006, 1'b0, 2'd2, 1'b1);
        resQ.push_back(32'd0);
        avsdm_src_model_i.pause(197);
        avsdm_src_model_i.vid(11'h006, 1'b0);
        apb(1'b1, 8'h00, 32'h10E);
        rd(8'h10, 33'h0);
        $display("audio-first test done");
        // Vertical interval: line 12 ignored, line 13 measured
        apb(1'b1, 8'h00, 32'h21);
        avsdm_src_model_i.gap();
        avsdm_src_model_i.vid(11'd12, 1'b0);
        avsdm_src_model_i.aud(11'd12, 1'b1, 2'd0, 1'b0);
        rd(8'h08, 33'h004);
        avsdm_src_model_i.vid(11'd13, 1'b0);
        resQ.push_back(32'd10);
        avsdm_src_model_i.pause(94);
        avsdm_src_model_i.aud(11'd13, 1'b1, 2'd0, 1'b0);
        $display("line gating test done");
        // Active video 625: line 45 audio ignored, lone line 38 video times out
        apb(1'b1, 8'h00, 32'hC1);
        avsdm_src_model_i.gap();
        avsdm_src_model_i.aud(11'd45, 1'b1, 2'd0, 1'b0);
        avsdm_src_model_i.vid(11'd38, 1'b0);
        avsdm_src_model_i.pause(2100);
        rd(8'h08, 33'h00C);
        $display("timeout test done");
        // Frames: rise out of vertical blanking ignored, video leads by three frames
        apb(1'b1, 8'h00, 32'h201);
        avsdm_src_model_i.gap();
        avsdm_src_model_i.vrise(11'd7);
        rd(8'h08, 33'h00C);
        avsdm_src_model_i.vid(11'd7, 1'b0);
        resQ.push_back(32'd3);
        avsdm_src_model_i.pause(297);
        avsdm_src_model_i.aud(11'd7, 1'b1, 2'd0, 1'b0);
        $display("frame test done");
        repeat (5) @(posedge clk);
        compares++;
        if (resQ.size() != 0)
            miss(33'(resQ.size()), 33'h0);
        end_of_test();
    end
endmodule : tb_avsdm_delay_meter
`default_nettype wire
